/* File: cle_counter_latch.sv */
`timescale 1ns/1ps
module cle_counter_latch (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [cle_pkg::CLE_AW-1:0] cpu_addr,
  input wire logic cpu_wr,
  input wire logic cpu_rd,
  input wire logic [cle_pkg::CLE_DW-1:0] cpu_wdata,
  output logic [cle_pkg::CLE_DW-1:0] cpu_rdata,
  input wire logic rising_edge_input,
  input wire logic falling_edge_input,
  input wire logic counter_io_line_in,
  output logic counter_io_line_out,
  output logic counter_io_line_oe,
  output logic irq_req
);
  import cle_pkg::*;

  logic [CLE_SYNC_N-1:0] sync_meta;
  logic [CLE_SYNC_N-1:0] sync_line;
  logic [CLE_SYNC_N-1:0] sync_prev;
  logic [CLE_DW-1:0] ctrl;
  logic [CLE_DW-1:0] preset_high_byte;
  logic [CLE_DW-1:0] preset_low_byte;
  logic [CLE_CW-1:0] count;

  wire [CLE_SYNC_N-1:0] raw_in = {counter_io_line_in, falling_edge_input,
                                  rising_edge_input};

  // Synchronise the three pins, keep one older sample for edges
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_meta <= CLE_SYNC_RESET;
      sync_line <= CLE_SYNC_RESET;
      sync_prev <= CLE_SYNC_RESET;
    end else begin
      sync_meta <= raw_in;
      sync_line <= sync_meta;
      sync_prev <= sync_line;
    end
  end

  // Edges need a high and a low sample, so two clocks at least
  wire rise_seen = sync_line[CLE_LANE_RISE] &&
                   !sync_prev[CLE_LANE_RISE];
  wire fall_seen = !sync_line[CLE_LANE_FALL] &&
                   sync_prev[CLE_LANE_FALL];
  wire io_level = sync_line[CLE_LANE_IO];
  wire io_rise = io_level && !sync_prev[CLE_LANE_IO];

  // Address decode
  wire wr_preset_hi = cpu_wr && (cpu_addr == CLE_ADDR_PRESET_HI);
  wire wr_preset_lo = cpu_wr && (cpu_addr == CLE_ADDR_PRESET_LO);
  wire wr_reload = cpu_wr && (cpu_addr == CLE_ADDR_RELOAD_CMD);
  wire wr_clr_rise = cpu_wr && (cpu_addr == CLE_ADDR_CLR_RISE);
  wire wr_clr_fall = cpu_wr && (cpu_addr == CLE_ADDR_CLR_FALL);
  wire wr_ctrl = cpu_wr && (cpu_addr == CLE_ADDR_CTRL);
  wire rd_count_hi = cpu_rd && (cpu_addr == CLE_ADDR_COUNT_HI);
  wire rd_count_lo = cpu_rd && (cpu_addr == CLE_ADDR_COUNT_LO);
  wire rd_ctrl = cpu_rd && (cpu_addr == CLE_ADDR_CTRL);

  // Mode and count qualification
  wire [1:0] mode = ctrl[CLE_BIT_MODE_HI:CLE_BIT_MODE_LO];
  wire mode_interval = (mode == CLE_MODE_INTERVAL);
  wire mode_pulse = (mode == CLE_MODE_PULSE);
  wire mode_event = (mode == CLE_MODE_EVENT);
  wire mode_width = (mode == CLE_MODE_WIDTH);

  wire cnt_tick = mode_interval || mode_pulse ||
                  (mode_event && io_rise) ||
                  (mode_width && !io_level);
  wire cnt_zero = (count == CLE_COUNT_ZERO);
  // A preset in the same cycle overrides the overflow
  wire ovf_evt = cnt_tick && cnt_zero && !wr_reload;

  wire [CLE_CW-1:0] preset_word = {cpu_wdata, preset_low_byte};
  wire [CLE_CW-1:0] latch_word = {preset_high_byte, preset_low_byte};
  wire [CLE_CW-1:0] next_count =
    wr_reload ? preset_word :
    ovf_evt ? latch_word :
    cnt_tick ? count - CLE_COUNT_ONE :
    count;

  // Latch and counter have no reset on purpose
  always_ff @(posedge clk) begin
    if (wr_preset_hi || wr_reload) begin
      preset_high_byte <= cpu_wdata;
    end
    if (wr_preset_lo) begin
      preset_low_byte <= cpu_wdata;
    end
  end

  always_ff @(posedge clk) begin
    count <= next_count;
  end

  // Status flags: the setting event wins over the clearing access
  wire next_ovf_flag = ovf_evt || (ctrl[CLE_BIT_OVF_FLAG] &&
                       !(rd_count_lo || wr_reload));
  wire next_rise_flag = rise_seen ||
                        (ctrl[CLE_BIT_RISE_FLAG] && !wr_clr_rise);
  wire next_fall_flag = fall_seen ||
                        (ctrl[CLE_BIT_FALL_FLAG] && !wr_clr_fall);
  wire [CLE_CTRL_WR_TOP:0] next_ctrl_bits =
    wr_ctrl ? cpu_wdata[CLE_CTRL_WR_TOP:0] : ctrl[CLE_CTRL_WR_TOP:0];
  wire [CLE_DW-1:0] next_ctrl = {next_ovf_flag, next_rise_flag,
                                 next_fall_flag, next_ctrl_bits};

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= CLE_CTRL_RESET;
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // Counter line: driven in the two clock modes only
  wire next_io_oe = mode_interval || mode_pulse;
  wire next_io_out = mode_pulse ?
    (counter_io_line_out ^ (ovf_evt || wr_reload)) :
    1'b1;

  wire next_irq = (ctrl[CLE_BIT_OVF_FLAG] && ctrl[CLE_BIT_OVF_EN]) ||
                  (ctrl[CLE_BIT_RISE_FLAG] && ctrl[CLE_BIT_RISE_EN]) ||
                  (ctrl[CLE_BIT_FALL_FLAG] && ctrl[CLE_BIT_FALL_EN]);

  // Read mux; unmapped and write-only addresses read zero
  wire [CLE_DW-1:0] rd_mux =
    rd_count_hi ? count[CLE_CW-1:CLE_DW] :
    rd_count_lo ? count[CLE_DW-1:0] :
    rd_ctrl ? ctrl :
    CLE_READ_ZERO;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      counter_io_line_out <= 1'b1;
      counter_io_line_oe <= 1'b1;
      irq_req <= 1'b0;
      cpu_rdata <= CLE_READ_ZERO;
    end else begin
      counter_io_line_out <= next_io_out;
      counter_io_line_oe <= next_io_oe;
      irq_req <= next_irq;
      if (cpu_rd) begin
        cpu_rdata <= rd_mux;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_RISE_SET: assert property (
    rise_seen |=> ctrl[CLE_BIT_RISE_FLAG])
    else $error("rising edge did not set its flag");

  AST_RISE_CLR: assert property (
    (wr_clr_rise && !rise_seen) |=> !ctrl[CLE_BIT_RISE_FLAG])
    else $error("rise flag not cleared by its write");

  AST_FALL_SET: assert property (
    fall_seen |=> ctrl[CLE_BIT_FALL_FLAG])
    else $error("falling edge did not set its flag");

  AST_FALL_CLR: assert property (
    (wr_clr_fall && !fall_seen) |=> !ctrl[CLE_BIT_FALL_FLAG])
    else $error("fall flag not cleared by its write");

  AST_RELOAD: assert property (
    (cnt_tick && cnt_zero && !wr_reload) |=>
      (count == $past(latch_word)) && ctrl[CLE_BIT_OVF_FLAG])
    else $error("overflow did not reload the latch");

  AST_DECR: assert property (
    (mode_interval && !cnt_zero && !wr_reload) |=>
      count == $past(count) - CLE_COUNT_ONE)
    else $error("interval mode did not decrement");

  AST_PRESET: assert property (
    wr_reload |=> (count == {$past(cpu_wdata), $past(preset_low_byte)}) &&
      (preset_high_byte == $past(cpu_wdata)))
    else $error("preset write did not load counter");

  AST_OVF_CLR: assert property (
    (rd_count_lo && !ovf_evt) |=> !ctrl[CLE_BIT_OVF_FLAG])
    else $error("low count read did not clear overflow");

  AST_IRQ: assert property (
    (ctrl[CLE_BIT_OVF_FLAG] && ctrl[CLE_BIT_OVF_EN]) ##1
      (ctrl[CLE_BIT_OVF_FLAG] && ctrl[CLE_BIT_OVF_EN]) |-> irq_req)
    else $error("enabled overflow raised no interrupt");

  AST_WIDTH_HOLD: assert property (
    (mode_width && io_level && !wr_reload) |=> $stable(count))
    else $error("width mode counted while line high");

  AST_PULSE_TOGGLE: assert property (
    (mode_pulse && wr_reload) |=>
      counter_io_line_out != $past(counter_io_line_out))
    else $error("preset in pulse mode did not toggle line");

  AST_CTRL_WR: assert property (
    wr_ctrl |=> ctrl[CLE_CTRL_WR_TOP:0] == $past(cpu_wdata[CLE_CTRL_WR_TOP:0]))
    else $error("control write not taken exactly");

  AST_INPUT_MODE: assert property (
    (mode_event || mode_width) |=> !counter_io_line_oe)
    else $error("counter line driven in an input mode");

  AST_OVF_SET: assert property (
    ovf_evt |=> ctrl[CLE_BIT_OVF_FLAG])
    else $error("overflow did not set its flag");

  AST_OVF_PRESET_CLR: assert property (
    wr_reload |=> !ctrl[CLE_BIT_OVF_FLAG])
    else $error("preset write did not clear overflow");

  AST_OVF_HOLD: assert property (
    (!ovf_evt && !rd_count_lo && !wr_reload) |=>
      $stable(ctrl[CLE_BIT_OVF_FLAG]))
    else $error("overflow flag changed without cause");

  AST_RISE_HOLD: assert property (
    (!rise_seen && !wr_clr_rise) |=> $stable(ctrl[CLE_BIT_RISE_FLAG]))
    else $error("rise flag changed without cause");

  AST_FALL_HOLD: assert property (
    (!fall_seen && !wr_clr_fall) |=> $stable(ctrl[CLE_BIT_FALL_FLAG]))
    else $error("fall flag changed without cause");

  AST_SET_WINS: assert property (
    (rise_seen && wr_clr_rise) |=> ctrl[CLE_BIT_RISE_FLAG])
    else $error("clearing write swallowed a rising edge");

  AST_CTRL_HOLD: assert property (
    !wr_ctrl |=> $stable(ctrl[CLE_CTRL_WR_TOP:0]))
    else $error("control bits changed without a write");

  AST_RISE_IRQ: assert property (
    (ctrl[CLE_BIT_RISE_FLAG] && ctrl[CLE_BIT_RISE_EN]) |=> irq_req)
    else $error("enabled rise flag raised no interrupt");

  AST_FALL_IRQ: assert property (
    (ctrl[CLE_BIT_FALL_FLAG] && ctrl[CLE_BIT_FALL_EN]) |=> irq_req)
    else $error("enabled fall flag raised no interrupt");

  AST_IRQ_QUIET: assert property (
    !((ctrl[CLE_BIT_OVF_FLAG] && ctrl[CLE_BIT_OVF_EN]) ||
      (ctrl[CLE_BIT_RISE_FLAG] && ctrl[CLE_BIT_RISE_EN]) ||
      (ctrl[CLE_BIT_FALL_FLAG] && ctrl[CLE_BIT_FALL_EN])) |=> !irq_req)
    else $error("interrupt raised with no enabled source");

  AST_RISE_SYNC: assert property (
    rise_seen |->
      $past(rising_edge_input, 2) && !$past(rising_edge_input, 3))
    else $error("rising edge seen that the pin never made");

  AST_FALL_SYNC: assert property (
    fall_seen |-> !$past(falling_edge_input, 2))
    else $error("falling edge seen while the pin was high");

  AST_IO_SYNC: assert property (
    io_rise |->
      $past(counter_io_line_in, 2) && !$past(counter_io_line_in, 3))
    else $error("line edge seen that the pin never made");

  AST_PULSE_OVF: assert property (
    (mode_pulse && ovf_evt) |=>
      counter_io_line_out != $past(counter_io_line_out))
    else $error("overflow in pulse mode did not toggle line");

  AST_PULSE_STILL: assert property (
    (mode_pulse && !ovf_evt && !wr_reload) |=>
      $stable(counter_io_line_out))
    else $error("pulse line toggled without cause");

  AST_PULSE_DECR: assert property (
    (mode_pulse && !cnt_zero && !wr_reload) |=>
      count == $past(count) - CLE_COUNT_ONE)
    else $error("pulse mode did not decrement");

  AST_EVENT_DECR: assert property (
    (mode_event && io_rise && !cnt_zero && !wr_reload) |=>
      count == $past(count) - CLE_COUNT_ONE)
    else $error("line edge did not decrement in event mode");

  AST_EVENT_HOLD: assert property (
    (mode_event && !io_rise && !wr_reload) |=> $stable(count))
    else $error("event mode counted without a line edge");

  AST_WIDTH_DECR: assert property (
    (mode_width && !io_level && !cnt_zero && !wr_reload) |=>
      count == $past(count) - CLE_COUNT_ONE)
    else $error("width mode did not count while line low");

  AST_LINE_HIGH: assert property (
    mode_interval |=> counter_io_line_out && counter_io_line_oe)
    else $error("interval mode did not drive line high");

  AST_OUTPUT_MODE: assert property (
    (mode_interval || mode_pulse) |=> counter_io_line_oe)
    else $error("counter line not driven in an output mode");

  AST_LATCH_HI: assert property (
    (wr_preset_hi || wr_reload) |=> preset_high_byte == $past(cpu_wdata))
    else $error("latch high byte not written");

  AST_LATCH_LO: assert property (
    wr_preset_lo |=> preset_low_byte == $past(cpu_wdata))
    else $error("latch low byte not written");

  AST_RD_COUNT_HI: assert property (
    rd_count_hi |=> cpu_rdata == $past(count[CLE_CW-1:CLE_DW]))
    else $error("high count read returned wrong byte");

  AST_RD_COUNT_LO: assert property (
    rd_count_lo |=> cpu_rdata == $past(count[CLE_DW-1:0]))
    else $error("low count read returned wrong byte");

  AST_RD_CTRL: assert property (
    rd_ctrl |=> cpu_rdata == $past(ctrl))
    else $error("control read returned wrong value");

  AST_RD_ZERO: assert property (
    (cpu_rd && !rd_count_hi && !rd_count_lo && !rd_ctrl) |=>
      cpu_rdata == CLE_READ_ZERO)
    else $error("write-only or unmapped read not zero");

  COV_OVERFLOW: cover property (ovf_evt ##1 irq_req);
  COV_EVENT_COUNT: cover property (mode_event && io_rise);
  COV_PULSE_TOGGLE: cover property (mode_pulse && ovf_evt);
  COV_EDGE_IRQ: cover property (rise_seen ##[1:4] irq_req);

endmodule : cle_counter_latch

/* File: cle_cpu_model.sv */
`timescale 1ns/1ps
module cle_cpu_model (
  input wire logic clk,
  input wire logic [cle_pkg::CLE_DW-1:0] cpu_rdata,
  output logic [cle_pkg::CLE_AW-1:0] cpu_addr,
  output logic cpu_wr,
  output logic cpu_rd,
  output logic [cle_pkg::CLE_DW-1:0] cpu_wdata
);
  import cle_pkg::*;
  initial begin
    cpu_addr = 12'h000;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    cpu_wdata = 8'h00;
  end
  // One access; released bus shows inverted values
  task acc(input logic w, input logic [CLE_AW-1:0] a,
      input logic [CLE_DW-1:0] d, output logic [CLE_DW-1:0] q);
    @(posedge clk);
    #1;
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = w;
    cpu_rd = !w;
    @(posedge clk);
    #1;
    q = cpu_rdata;
    cpu_wr = 1'b0;
    cpu_rd = 1'b0;
    cpu_addr = ~a;
    cpu_wdata = ~d;
  endtask : acc
endmodule : cle_cpu_model

/* File: cle_pkg.sv */
package cle_pkg;

  // Processor bus geometry
  localparam int CLE_AW = 12;
  localparam int CLE_DW = 8;
  localparam int CLE_CW = 16;

  // Register map
  localparam logic [CLE_AW-1:0] CLE_ADDR_PRESET_HI = 12'h084;
  localparam logic [CLE_AW-1:0] CLE_ADDR_PRESET_LO = 12'h085;
  localparam logic [CLE_AW-1:0] CLE_ADDR_COUNT_HI = 12'h086;
  localparam logic [CLE_AW-1:0] CLE_ADDR_COUNT_LO = 12'h087;
  localparam logic [CLE_AW-1:0] CLE_ADDR_RELOAD_CMD = 12'h088;
  localparam logic [CLE_AW-1:0] CLE_ADDR_CLR_RISE = 12'h089;
  localparam logic [CLE_AW-1:0] CLE_ADDR_CLR_FALL = 12'h08A;
  localparam logic [CLE_AW-1:0] CLE_ADDR_CTRL = 12'h08B;

  // Control register fields
  localparam int CLE_BIT_OVF_FLAG = 7;
  localparam int CLE_BIT_RISE_FLAG = 6;
  localparam int CLE_BIT_FALL_FLAG = 5;
  localparam int CLE_BIT_OVF_EN = 4;
  localparam int CLE_BIT_RISE_EN = 3;
  localparam int CLE_BIT_FALL_EN = 2;
  localparam int CLE_BIT_MODE_HI = 1;
  localparam int CLE_BIT_MODE_LO = 0;
  localparam int CLE_CTRL_WR_TOP = 4;
  localparam logic [CLE_DW-1:0] CLE_CTRL_RESET = 8'h00;

  // Counter modes, upper select bit first
  localparam logic [1:0] CLE_MODE_INTERVAL = 2'h0;
  localparam logic [1:0] CLE_MODE_PULSE = 2'h1;
  localparam logic [1:0] CLE_MODE_EVENT = 2'h2;
  localparam logic [1:0] CLE_MODE_WIDTH = 2'h3;

  // Synchroniser lanes
  localparam int CLE_SYNC_N = 3;
  localparam int CLE_LANE_RISE = 0;
  localparam int CLE_LANE_FALL = 1;
  localparam int CLE_LANE_IO = 2;
  localparam logic [CLE_SYNC_N-1:0] CLE_SYNC_RESET = 3'h7;

  localparam logic [CLE_CW-1:0] CLE_COUNT_ZERO = 16'h0000;
  localparam logic [CLE_CW-1:0] CLE_COUNT_ONE = 16'h0001;
  localparam logic [CLE_DW-1:0] CLE_READ_ZERO = 8'h00;

endpackage : cle_pkg

/* File: tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import cle_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic rise_pin = 1'b1;
  logic fall_pin = 1'b1;
  logic ext_line = 1'b1;
  logic [CLE_AW-1:0] cpu_addr;
  logic cpu_wr;
  logic cpu_rd;
  logic [CLE_DW-1:0] cpu_wdata;
  logic [CLE_DW-1:0] cpu_rdata;
  logic io_out;
  logic io_oe;
  logic irq;
  logic [7:0] q;
  logic lv;
  int failures = 0;
  int check_count = 0;
  int n;
  logic [39:0] rows [7] = '{40'h08B1F08B1F, 40'h08BE208B02,
    40'h084F008400, 40'h0850008500, 40'h089FF08A00,
    40'h08A000FF00, 40'h0867708B02};
  // Pull-up holds the line high when nobody drives it
  wire io_line = io_oe ? io_out : ext_line;
  always #2.5 clk = ~clk;
  cle_cpu_model cle_cpu_model_inst (.clk(clk), .cpu_rdata(cpu_rdata),
    .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_wdata(cpu_wdata));
  cle_counter_latch cle_counter_latch_inst (.clk(clk), .rstn(rstn),
    .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .rising_edge_input(rise_pin), .falling_edge_input(fall_pin),
    .counter_io_line_in(io_line), .counter_io_line_out(io_out),
    .counter_io_line_oe(io_oe), .irq_req(irq));
  task complete_run;
    if (failures == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task chk(input string s, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc
  task wr(input logic [11:0] a, input logic [7:0] d);
    cle_cpu_model_inst.acc(1'b1, a, d, q);
  endtask : wr
  task rd(input logic [11:0] a, input logic [7:0] e);
    cle_cpu_model_inst.acc(1'b0, a, 8'h00, q);
    chk($sformatf("read %h", a), e, q);
  endtask : rd
  task wait_tog(output int k);
    lv = io_line;
    k = 0;
    do begin
      cyc(1);
      k++;
    end while (io_line === lv && k < 50);
  endtask : wait_tog
  task edge_t(input bit fall, input logic [7:0] flag,
      input logic [11:0] clr, input logic [7:0] d);
    wr(CLE_ADDR_CTRL, 8'h0C);
    if (fall) fall_pin = 1'b0;
    else rise_pin = 1'b0;
    cyc(3);
    rise_pin = 1'b1;
    fall_pin = 1'b1;
    cyc(6);
    rd(CLE_ADDR_CTRL, flag | 8'h0C);
    chk("irq set", 8'h01, 8'(irq));
    wr(clr, d);
    cyc(2);
    rd(CLE_ADDR_CTRL, 8'h0C);
    chk("irq clear", 8'h00, 8'(irq));
  endtask : edge_t
  initial begin
    cyc(3);
    rstn = 1'b1;
    chk("line out", 8'h01, 8'(io_out));
    chk("line oe", 8'h01, 8'(io_oe));
    chk("irq", 8'h00, 8'(irq));
    wr(CLE_ADDR_PRESET_HI, 8'hF0);
    wr(CLE_ADDR_PRESET_LO, 8'h00);
    wr(CLE_ADDR_RELOAD_CMD, 8'hF0);
    rd(CLE_ADDR_CTRL, 8'h00);
    foreach (rows[i]) begin
      wr(rows[i][39:28], rows[i][27:20]);
      rd(rows[i][19:8], rows[i][7:0]);
    end
    wr(CLE_ADDR_CTRL, 8'h00);
    wr(CLE_ADDR_PRESET_HI, 8'h00);
    wr(CLE_ADDR_PRESET_LO, 8'h04);
    wr(CLE_ADDR_RELOAD_CMD, 8'h00);
    wr(CLE_ADDR_CTRL, 8'h11);
    wait_tog(n);
    repeat (2) begin
      wait_tog(n);
      chk("toggle period", 8'h05, 8'(n));
    end
    wr(CLE_ADDR_PRESET_HI, 8'h02);
    wr(CLE_ADDR_PRESET_LO, 8'hF0);
    cyc(12);
    rd(CLE_ADDR_CTRL, 8'h91);
    chk("irq ovf", 8'h01, 8'(irq));
    cle_cpu_model_inst.acc(1'b0, CLE_ADDR_COUNT_LO, 8'h00, q);
    rd(CLE_ADDR_CTRL, 8'h11);
    chk("irq ovf clr", 8'h00, 8'(irq));
    rd(CLE_ADDR_COUNT_HI, 8'h02);
    lv = io_line;
    wr(CLE_ADDR_RELOAD_CMD, 8'h03);
    cyc(1);
    chk("preset toggle", 8'(!lv), 8'(io_line));
    rd(CLE_ADDR_COUNT_HI, 8'h03);
    edge_t(1'b0, 8'h40, CLE_ADDR_CLR_RISE, 8'h00);
    edge_t(1'b1, 8'h20, CLE_ADDR_CLR_FALL, 8'hFF);
    chk("line interval", 8'h01, 8'(io_line));
    wr(CLE_ADDR_CTRL, 8'h02);
    cyc(1);
    chk("oe event", 8'h00, 8'(io_oe));
    wr(CLE_ADDR_PRESET_HI, 8'h00);
    wr(CLE_ADDR_RELOAD_CMD, 8'h00);
    repeat (3) begin
      ext_line = 1'b0;
      cyc(2);
      ext_line = 1'b1;
      cyc(2);
    end
    cyc(4);
    rd(CLE_ADDR_COUNT_LO, 8'hED);
    wr(CLE_ADDR_CTRL, 8'h03);
    wr(CLE_ADDR_RELOAD_CMD, 8'h00);
    cyc(4);
    rd(CLE_ADDR_COUNT_LO, 8'hF0);
    ext_line = 1'b0;
    cyc(10);
    ext_line = 1'b1;
    cyc(5);
    rd(CLE_ADDR_COUNT_LO, 8'hE6);
    rstn = 1'b0;
    cyc(2);
    chk("reset oe", 8'h01, 8'(io_oe));
    rstn = 1'b1;
    rd(CLE_ADDR_CTRL, 8'h00);
    rd(CLE_ADDR_COUNT_HI, 8'h00);
    complete_run();
  end
  initial begin
    #20000;
    failures++;
    complete_run();
  end
endmodule : tb_top
